/* include/eeb_regs.svh */
// Constants of the two-wire EEPROM bus interface.
`ifndef EEB_REGS_SVH
`define EEB_REGS_SVH

`define EEB_MCLK_HZ      100000000
`define EEB_EW_TIME_MS   10
`define EEB_EW_CYCLES    ((`EEB_EW_TIME_MS * `EEB_MCLK_HZ) / 1000)
`define EEB_EW_CW        20
`define EEB_ADDR_W       11
`define EEB_MEM_BYTES    2048
`define EEB_PAGE_W       5
`define EEB_BYTE_BITS    4'h8
`define EEB_LAST_BIT     4'h7
`define EEB_STATE_RST    '0

`endif

/* include/eeb_pkg.sv */
// Types shared by the two-wire EEPROM bus interface.
`include "eeb_regs.svh"

package eeb_pkg;

	typedef logic [`EEB_EW_CW-1:0]  eeb_cnt_t;
	typedef logic [`EEB_ADDR_W-1:0] eeb_addr_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_RX,
		PH_RXACK,
		PH_TX,
		PH_TXACK
	} eeb_phase_t;

	typedef enum logic [1:0] {
		K_DEV,
		K_WORD,
		K_DATA
	} eeb_kind_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
	} eeb_pins_t;

	typedef struct packed {
		eeb_pins_t  meta;
		eeb_pins_t  sync;
		eeb_pins_t  prev;
		eeb_phase_t phase;
		eeb_kind_t  kind;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		eeb_addr_t  addr;
		logic       rw;
		logic       mAck;
		logic       wrote;
		logic       sdaOe;
		logic       sdaOut;
	} eeb_state_t;

	typedef struct packed {
		logic     busy;
		eeb_cnt_t cnt;
	} eeb_tmr_t;

endpackage : eeb_pkg

/* src/eeb_ew_timer.sv */
// Erase/write cycle timer of the two-wire EEPROM.
`timescale 1ns/10ps
`default_nettype none

module eeb_ew_timer #(
	parameter int unsigned CYCLES = `EEB_EW_CYCLES // Cycle length in mclk periods.
) (
	input  wire logic mclk,  // System clock.
	input  wire logic rstN,  // Synchronised reset, active low.
	input  wire logic ce,    // Clock enable.
	input  wire logic start, // One-cycle request to begin a cycle.
	output logic      busy   // High while the cycle runs.
);

	localparam eeb_pkg::eeb_cnt_t LAST = eeb_pkg::eeb_cnt_t'(CYCLES - 1);

	eeb_pkg::eeb_tmr_t st;
	eeb_pkg::eeb_tmr_t next_st;

	// The cycle is timed here alone; nothing outside supplies a time base. R21
	always_comb begin
		next_st = st;
		if (ce) begin
			if (st.busy) begin
				if (st.cnt == LAST) begin
					next_st.busy = 1'b0;
					next_st.cnt  = '0;
				end else begin
					next_st.cnt = st.cnt + eeb_pkg::eeb_cnt_t'(1);
				end
			end else if (start) begin
				next_st.busy = 1'b1;
				next_st.cnt  = '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			st <= `EEB_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	timer_start_a: assert property (ce && start && !st.busy |=> st.busy) // R21
		else $error("erase/write timer did not start");

endmodule : eeb_ew_timer

`default_nettype wire

/* src/eeb_bus_slave.sv */
// Two-wire bus slave of a 2048-byte EEPROM, with its storage array.
// Contract
// R1: Write-protect high: received data bytes get no acknowledge, memory unchanged.
// R2: Storage is 2048 bytes, eight blocks of 256, one bus device.
// R3: Every byte moves most significant bit first.
// R4: Address byte: four device-type bits, three block bits, read/write bit.
// R5: Data falling while clock high is START, opening a transfer.
// R6: Data rising while clock high is STOP, closing a transfer.
// R7: Data changes only while clock low; change during high is control.
// R8: One data bit per clock pulse, valid while stable through clock high.
// R9: Bus idle while data and clock both stay high.
// R10: Master starts a transfer only on an idle bus.
// R11: Transfers run START to STOP; at most 32 data bytes when writing.
// R12: Reads continue as long as the master keeps clocking.
// R13: Each byte is followed by a ninth acknowledge bit from the receiver.
// R14: Master supplies the ninth clock pulse after every byte.
// R15: Addressed receiving device acknowledges every byte unless suppressed.
// R16: Reading master acknowledges every byte except the last.
// R17: Acknowledger holds data low through the whole acknowledge clock high.
// R18: Master ends a read by not acknowledging the last byte.
// R19: After an unacknowledged sent byte, device releases data for STOP.
// R20: Only 100 kHz and 400 kHz bus rates; no 3.2 MHz mode.
// R21: Erase/write cycle is timed internally.
// R22: Block bits are the top three of the eleven-bit address.
// R23: Lowest address bit one selects read, zero selects write.
// R24: After a write STOP, 10 ms erase/write; address not acknowledged meanwhile.
// R25: Writes increment only the five low address bits, wrapping in page.
// R26: Device-type mismatch: no acknowledge, ignore until next START.
`timescale 1ns/10ps
`default_nettype none

module eeb_bus_slave #(
	parameter logic [3:0]  DEV_TYPE  = 4'h5,          // Device-type pattern, value arbitrary.
	parameter int unsigned EW_CYCLES = `EEB_EW_CYCLES // Erase/write length in mclk cycles.
) (
	input  wire logic mclk,   // System clock, 100 MHz.
	input  wire logic nrst,   // Asynchronous reset, active low.
	input  wire logic ce,     // Clock enable; low freezes all state except the reset release flops rstMeta and rstN.
	input  wire logic sclIn,  // Bus clock pin level.
	input  wire logic sdaIn,  // Bus data pin level.
	input  wire logic wpIn,   // Write-protect pin, high protects.
	output logic      sdaOut, // Data pin drive value, always low.
	output logic      sdaOe,  // Data pin pull-down enable, high drives.
	output logic      ewBusy  // Erase/write cycle in progress.
);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release and storage.

	logic rstMeta;
	logic rstN;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN    <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN    <= rstMeta;
		end
	end

	// Eight blocks of 256 bytes behind one bus address. R2
	logic [7:0] mem [`EEB_MEM_BYTES];
	logic [7:0] memQ;
	logic       memWe;

	eeb_pkg::eeb_state_t st;
	eeb_pkg::eeb_state_t next_st;

	assign memQ = mem[st.addr];

	always_ff @(posedge mclk) begin
		if (memWe) begin
			mem[st.addr] <= st.shift;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus conditions.

	logic scl;
	logic sda;
	logic wp;
	logic sclRise;
	logic sclFall;
	logic startDet;
	logic stopDet;
	logic ctlEvt;
	logic devHit;
	logic loadTx;
	logic ewStart;

	// Pins pass two flops; at 100 MHz a 400 kHz bus gives over 100 samples a bit. R20
	assign scl      = st.sync.scl;
	assign sda      = st.sync.sda;
	assign wp       = st.sync.wp;
	assign sclRise  = !st.prev.scl && scl;
	assign sclFall  = st.prev.scl && !scl;
	assign startDet = st.prev.scl && scl && st.prev.sda && !sda; // R5
	assign stopDet  = st.prev.scl && scl && !st.prev.sda && sda; // R6
	assign ctlEvt   = startDet || stopDet; // R7
	// A busy erase/write cycle hides the device, as does a foreign type. R24 R26
	assign devHit   = (st.shift[7:4] == DEV_TYPE) && !ewBusy; // R4

	////////////////////////////////////////////////////////////////////////////////
	// Bit and byte sequencing.

	always_comb begin
		next_st      = st;
		memWe        = 1'b0;
		ewStart      = 1'b0;
		loadTx       = 1'b0;
		next_st.meta = {sclIn, sdaIn, wpIn};
		next_st.sync = st.meta;
		next_st.prev = st.sync;
		if (startDet) begin
			next_st.phase  = eeb_pkg::PH_RX; // R5
			next_st.kind   = eeb_pkg::K_DEV;
			next_st.bitCnt = '0;
			next_st.sdaOe  = 1'b0;
		end else if (stopDet) begin
			next_st.phase = eeb_pkg::PH_IDLE; // R6 R9
			next_st.sdaOe = 1'b0;
			if (st.wrote) begin
				ewStart       = 1'b1; // R24
				next_st.wrote = 1'b0;
			end
		end else begin
			unique case (st.phase)
				eeb_pkg::PH_IDLE: begin
				end
				eeb_pkg::PH_RX: begin
					if (sclRise && st.bitCnt != `EEB_BYTE_BITS) begin
						next_st.shift  = {st.shift[6:0], sda}; // R3 R8
						next_st.bitCnt = st.bitCnt + 4'h1;
					end else if (sclFall && st.bitCnt == `EEB_BYTE_BITS) begin
						next_st.phase = eeb_pkg::PH_RXACK; // R13
						unique case (st.kind)
							eeb_pkg::K_DEV: begin
								if (devHit) begin
									next_st.addr[10:8] = st.shift[3:1]; // R22
									next_st.rw         = st.shift[0]; // R23
									next_st.sdaOe      = 1'b1; // R15
								end else begin
									next_st.phase = eeb_pkg::PH_IDLE; // R26 R24
								end
							end
							eeb_pkg::K_WORD: begin
								next_st.addr[7:0] = st.shift;
								next_st.sdaOe     = 1'b1; // R15
							end
							eeb_pkg::K_DATA: begin
								// Protected bytes leave no trace and get no acknowledge. R1
								if (!wp) begin
									memWe              = 1'b1;
									next_st.addr[4:0]  = st.addr[4:0] + 5'h01; // R25
									next_st.wrote      = 1'b1;
									next_st.sdaOe      = 1'b1; // R15
								end
							end
						endcase
					end
				end
				eeb_pkg::PH_RXACK: begin
					// The pull-down stands until the acknowledge pulse falls. R17
					if (sclFall) begin
						next_st.sdaOe  = 1'b0;
						next_st.bitCnt = '0;
						if (st.kind == eeb_pkg::K_DEV && st.rw) begin
							loadTx = 1'b1; // R23
						end else begin
							next_st.phase = eeb_pkg::PH_RX;
							if (st.kind == eeb_pkg::K_DEV) begin
								next_st.kind = eeb_pkg::K_WORD;
							end else begin
								next_st.kind = eeb_pkg::K_DATA;
							end
						end
					end
				end
				eeb_pkg::PH_TX: begin
					if (sclFall) begin
						if (st.bitCnt == `EEB_LAST_BIT) begin
							next_st.phase = eeb_pkg::PH_TXACK; // R14
							next_st.sdaOe = 1'b0;
						end else begin
							next_st.shift  = {st.shift[6:0], 1'b0}; // R3
							next_st.sdaOe  = !st.shift[6]; // R7
							next_st.bitCnt = st.bitCnt + 4'h1;
						end
					end
				end
				eeb_pkg::PH_TXACK: begin
					if (sclRise) begin
						next_st.mAck = !sda; // R16
					end else if (sclFall) begin
						if (st.mAck) begin
							loadTx         = 1'b1; // R12
							next_st.bitCnt = '0;
						end else begin
							// Leave the line high so the master can make its STOP. R18 R19
							next_st.phase = eeb_pkg::PH_IDLE;
							next_st.sdaOe = 1'b0;
						end
					end
				end
			endcase
		end
		if (loadTx) begin
			next_st.phase = eeb_pkg::PH_TX;
			next_st.shift = memQ;
			next_st.sdaOe = !memQ[7]; // R3
			next_st.addr  = st.addr + eeb_pkg::eeb_addr_t'(1); // R12
		end
		next_st.sdaOut = 1'b0;
		if (!ce) begin
			next_st = st;
			memWe   = 1'b0;
			ewStart = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			st <= `EEB_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign sdaOe  = st.sdaOe;
	assign sdaOut = st.sdaOut;

	eeb_ew_timer #(
		.CYCLES (EW_CYCLES)
	) u_timer (
		.mclk  (mclk),
		.rstN  (rstN),
		.ce    (ce),
		.start (ewStart), // R21
		.busy  (ewBusy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	sequence rxByteEnd;
		ce && sclFall && st.phase == eeb_pkg::PH_RX && st.bitCnt == `EEB_BYTE_BITS;
	endsequence

	sequence devByteEnd;
		rxByteEnd and (st.kind == eeb_pkg::K_DEV);
	endsequence

	wp_no_ack_a: assert property ( // R1
		rxByteEnd and (st.kind == eeb_pkg::K_DATA && wp) |=> !st.sdaOe && !$past(memWe))
		else $error("protected data byte was acknowledged or written");

	msb_first_a: assert property ( // R3
		st.phase == eeb_pkg::PH_TX |-> st.sdaOe == !st.shift[7])
		else $error("sent bit is not the top bit of the shift register");

	start_seen_a: assert property ( // R5
		ce && startDet |=> st.phase == eeb_pkg::PH_RX && st.kind == eeb_pkg::K_DEV
			&& st.bitCnt == 4'h0)
		else $error("START did not open address reception");

	stop_seen_a: assert property ( // R6
		ce && stopDet |=> st.phase == eeb_pkg::PH_IDLE && !st.sdaOe)
		else $error("STOP did not return the slave to idle");

	drive_clock_low_a: assert property ( // R7
		$changed(st.sdaOe) && !$past(ctlEvt) |-> !$past(scl))
		else $error("data drive changed while clock was high");

	one_bit_a: assert property ( // R8
		ce && sclRise && st.phase == eeb_pkg::PH_RX && st.bitCnt < `EEB_BYTE_BITS
			&& !ctlEvt |=> st.bitCnt == $past(st.bitCnt) + 4'h1)
		else $error("clock pulse did not take exactly one bit");

	dev_ack_a: assert property ( // R22
		devByteEnd and (devHit) |=> st.sdaOe && st.addr[10:8] == $past(st.shift[3:1]))
		else $error("matching address byte not acknowledged or block lost");

	busy_nack_a: assert property ( // R24
		devByteEnd and (ewBusy) |=> !st.sdaOe ##1 st.phase == eeb_pkg::PH_IDLE || !ce)
		else $error("address acknowledged during erase/write");

	nack_release_a: assert property ( // R19
		ce && sclFall && st.phase == eeb_pkg::PH_TXACK && !st.mAck && !ctlEvt
			|=> !st.sdaOe && st.phase == eeb_pkg::PH_IDLE)
		else $error("data line not released after unacknowledged byte");

	page_wrap_a: assert property ( // R25
		memWe |=> st.addr[10:5] == $past(st.addr[10:5])
			&& st.addr[4:0] == $past(st.addr[4:0]) + 5'h01)
		else $error("write address left its page");

	ack_hold_a: assert property ( // R17
		st.phase == eeb_pkg::PH_RXACK && st.sdaOe && scl && ce && !ctlEvt |=> st.sdaOe)
		else $error("acknowledge released during clock high");

	stop_ew_a: assert property ( // R24
		ce && stopDet && st.wrote |=> ##1 ewBusy)
		else $error("erase/write did not start after write STOP");

endmodule : eeb_bus_slave

`default_nettype wire

/* sim/eeb_master_model.sv */
// Behavioural two-wire bus master that drives the far side of the slave.
`timescale 1ns/10ps
`default_nettype none

module eeb_master_model (
	input  wire logic      sdaWire,  // Resolved data line.
	output var logic       sclOut,   // Bus clock, high while idle.
	output var logic       sdaLow,   // High while the master pulls data low.
	output var logic       resPulse, // Toggles once per result.
	output var logic [7:0] resData   // Acknowledge level or read byte.
);
	localparam realtime Q = 31.25;

	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
		resPulse = 1'b0;
		resData = 8'h00;
	end

	////////////////////////////////////////
	task automatic post(input logic [7:0] v);
		resData = v;
		resPulse = ~resPulse;
	endtask : post

	task automatic putBit(input logic b);
		#Q sdaLow = ~b;
		#Q sclOut = 1'b1;
		#(2*Q) sclOut = 1'b0;
	endtask : putBit

	// Sampling just before the fall gives the slave the whole low phase to answer.
	task automatic getBit(output logic b);
		#Q sdaLow = 1'b0;
		#Q sclOut = 1'b1;
		#(2*Q-1) b = sdaWire;
		#1 sclOut = 1'b0;
	endtask : getBit

	task automatic start;
		if (!sclOut) begin
			#Q sdaLow = 1'b0;
			#Q sclOut = 1'b1;
		end
		#Q sdaLow = 1'b1;
		#Q sclOut = 1'b0;
	endtask : start

	task automatic stop;
		#Q sdaLow = 1'b1;
		#Q sclOut = 1'b1;
		#Q sdaLow = 1'b0;
		#Q;
	endtask : stop

	task automatic wrByte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			putBit(v[i]);
		end
		getBit(a);
		post({7'h00, a});
	endtask : wrByte

	task automatic rdByte(input logic last);
		logic [7:0] v;
		for (int i = 7; i >= 0; i--) begin
			getBit(v[i]);
		end
		post(v);
		putBit(last);
		if (last) begin
			#(2*Q) post({7'h00, sdaWire});
		end
	endtask : rdByte
endmodule : eeb_master_model
`default_nettype wire

/* sim/eeb_bus_slave_tb_top.sv */
// Self-checking bench of the two-wire EEPROM slave against a behavioural master.
`timescale 1ns/10ps
`default_nettype none

`define CHECK(what, expv, gotv) \
	begin \
		compares++; \
		if ((gotv) !== (expv)) begin \
			bad_count++; \
			$display("Error %s expected %h seen %h", what, expv, gotv); \
		end \
	end

module eeb_bus_slave_tb_top;
	typedef struct {
		string      what;
		logic [7:0] val;
	} eeb_note_t;

	logic       mclk;
	logic       nrst;
	logic       ce;
	logic       wpIn;
	logic       sdaOut;
	logic       sdaOe;
	logic       ewBusy;
	logic       sclOut;
	logic       sdaLow;
	logic       resPulse;
	logic [7:0] resData;
	logic       probeTgl;
	logic [7:0] probeData;
	wire logic  sdaWire;
	int         bad_count;
	int         compares;
	eeb_note_t  notes[$];
	logic [2:0] blk;
	logic [7:0] dat[3];

	// Released data floats high through the pull-up.
	assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	eeb_bus_slave #(
		.EW_CYCLES(200)
	) eeb_bus_slave_inst (
		.mclk  (mclk),
		.nrst  (nrst),
		.ce    (ce),
		.sclIn (sclOut),
		.sdaIn (sdaWire),
		.wpIn  (wpIn),
		.sdaOut(sdaOut),
		.sdaOe (sdaOe),
		.ewBusy(ewBusy)
	);

	eeb_master_model eeb_master_model_inst (
		.sdaWire (sdaWire),
		.sclOut  (sclOut),
		.sdaLow  (sdaLow),
		.resPulse(resPulse),
		.resData (resData)
	);

	////////////////////////////////////////
	task automatic give_verdict;
		$display("TB: counts compares=%0d mismatches=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic note(input string w, input logic [7:0] v);
		notes.push_back('{w, v});
	endtask : note

	task automatic take(input logic [7:0] got);
		eeb_note_t n;
		n = '{"unexpected result", 8'hXX};
		if (notes.size() > 0) begin
			n = notes.pop_front();
		end
		`CHECK(n.what, n.val, got)
	endtask : take

	initial begin
		#1;
		fork
			forever @(resPulse) take(resData);
			forever @(probeTgl) take(probeData);
		join_none
	end

	task automatic probeBusy(input logic exp);
		note("erase busy", {7'h00, exp});
		repeat (4) @(negedge mclk);
		probeData = {7'h00, ewBusy};
		probeTgl = ~probeTgl;
	endtask : probeBusy

	task automatic devByte(input logic [3:0] kind, input logic rd, input logic ack);
		note("address ack", {7'h00, ~ack});
		eeb_master_model_inst.start();
		eeb_master_model_inst.wrByte({kind, blk, rd});
	endtask : devByte

	task automatic sendByte(input logic [7:0] v, input logic ack);
		note("byte ack", {7'h00, ~ack});
		eeb_master_model_inst.wrByte(v);
	endtask : sendByte

	task automatic readAt(input logic [7:0] word, input logic [7:0] exp[$]);
		devByte(4'h5, 1'b0, 1'b1);
		sendByte(word, 1'b1);
		devByte(4'h5, 1'b1, 1'b1);
		foreach (exp[i]) begin
			note("read byte", exp[i]);
			if (i == exp.size() - 1) begin
				note("data released", 8'h01);
			end
			eeb_master_model_inst.rdByte(i == exp.size() - 1);
		end
		eeb_master_model_inst.stop();
	endtask : readAt

	task automatic waitIdle;
		int k;
		k = 0;
		while (ewBusy !== 1'b0 && k < 400) begin
			@(negedge mclk);
			k++;
		end
		if (k == 400) begin
			bad_count++;
			$display("Error erase wait expected done seen busy");
			give_verdict();
		end
	endtask : waitIdle

	initial begin
		#300us;
		bad_count++;
		$display("Error run time expected end seen hang");
		give_verdict();
	end

	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		wpIn = 1'b0;
		probeTgl = 1'b0;
		probeData = 8'h00;
		bad_count = 0;
		compares = 0;
		void'($urandom(31295));
		blk = 3'($urandom_range(7, 0));
		foreach (dat[i]) dat[i] = 8'($urandom);
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		repeat (8) @(negedge mclk);
		// Three bytes from the last page slot must wrap to slot zero.
		devByte(4'h5, 1'b0, 1'b1);
		sendByte(8'h1F, 1'b1);
		foreach (dat[i]) sendByte(dat[i], 1'b1);
		eeb_master_model_inst.stop();
		probeBusy(1'b1);
		// With the enable low the timer must hold, so busy outlives its 200 cycles.
		ce = 1'b0;
		repeat (300) @(negedge mclk);
		probeBusy(1'b1);
		ce = 1'b1;
		devByte(4'h5, 1'b0, 1'b0);
		eeb_master_model_inst.stop();
		$display("test page write done");
		waitIdle();
		readAt(8'h1F, '{dat[0]});
		readAt(8'h00, '{dat[1], dat[2]});
		$display("test read back done");
		wpIn = 1'b1;
		devByte(4'h5, 1'b0, 1'b1);
		sendByte(8'h00, 1'b1);
		sendByte(~dat[1], 1'b0);
		sendByte(~dat[2], 1'b0);
		eeb_master_model_inst.stop();
		probeBusy(1'b0);
		wpIn = 1'b0;
		readAt(8'h00, '{dat[1], dat[2]});
		$display("test write protect done");
		devByte(4'h3, 1'b0, 1'b0);
		sendByte(8'h00, 1'b0);
		eeb_master_model_inst.stop();
		$display("test foreign type done");
		repeat (10) @(negedge mclk);
		`CHECK("data drive level", 8'h00, {7'h00, sdaOut})
		if (notes.size() != 0) begin
			bad_count++;
			$display("Error results expected all seen %0d missing", notes.size());
		end
		give_verdict();
	end
endmodule : eeb_bus_slave_tb_top
`default_nettype wire
